//--- hw/pmc_defines.svh
// Register offsets, field positions, reset values and timing figures
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_ADDR_W 4
`define PMC_OFS_FOSC 4'h0
`define PMC_OFS_SCC 4'h4
`define PMC_OFS_WAKE 4'h8
`define PMC_OFS_STAT 4'hC
`define PMC_FOSC_EN_BIT 0
`define PMC_FOSC_STB_BIT 1
`define PMC_FOSC_FRQ_LO 2
`define PMC_SCC_SKEEP_BIT 0
`define PMC_SCC_FKEEP_BIT 1
`define PMC_SCC_SEL_LO 5
`define PMC_FOSC_EN_RST 1'b1
`define PMC_FOSC_FRQ_RST 2'h0
`define PMC_SCC_SEL_RST 3'h0
`define PMC_SEL_SUB 3'h7
`define PMC_FRQ_4M 2'h0
`define PMC_FRQ_8M 2'h1
`define PMC_FRQ_12M 2'h2
`define PMC_CLK_PERIOD_NS 4
`define PMC_FAST_PERIOD_NS 250
`define PMC_SUB_PERIOD_NS 31250
`define PMC_SWITCH_PERIODS 4
`define PMC_FAST_SETTLE_NS 256
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`endif

//--- hw/pmc_pkg.sv
// Types shared by the power mode clock controller
`default_nettype none
package pmc_pkg;
  typedef enum logic [5:0] {
    PMC_FAST = 6'h01,
    PMC_SLOW = 6'h02,
    PMC_SLEEP = 6'h04,
    PMC_IDLE_SUB = 6'h08,
    PMC_IDLE_BOTH = 6'h10,
    PMC_IDLE_FAST = 6'h20
  } pmc_mode_t;
  // Clock and power controls to the chip
  typedef struct packed {
    logic cpuRun;
    logic sysClkOn;
    logic fastClkOn;
    logic subClkOn;
    logic fastOscOn;
    logic holdState;
    logic [2:0] sysClkSel;
    logic [1:0] fastFreq;
  } pmc_clk_t;
  // One-cycle event pulses to the core
  typedef struct packed {
    logic wdtClear;
    logic pcSpReset;
    logic resumeNext;
    logic irqService;
  } pmc_evt_t;
endpackage : pmc_pkg
`default_nettype wire

//--- hw/pmc_power_ctrl.sv
// Power mode and system clock controller with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module pmc_power_ctrl import pmc_pkg::*; #(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 8,
  parameter int SUB_PERIOD_CYC = `PMC_SUB_PERIOD_NS / `PMC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic [`PMC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`PMC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  input wire logic haltReq,
  input wire logic clrWdtReq,
  input wire logic wdtOverflow,
  input wire logic [IRQ_W-1:0] irqReq,
  input wire logic [IRQ_W-1:0] irqEnable,
  input wire logic stackFull,
  input wire logic [PORT_W-1:0] portAIn,
  input wire logic fastOscReady,
  input wire logic slowOscStable,
  output pmc_clk_t clkCtl,
  output pmc_evt_t evt,
  output logic powerdownFlag,
  output logic wdtTimeoutFlag
);
  localparam int FAST_PERIOD_CYC = `PMC_FAST_PERIOD_NS / `PMC_CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (`PMC_FAST_SETTLE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS;

  // Frequency code decode, 11 aliases to 4 MHz
  function automatic logic [1:0] decodeFreq(input logic [1:0] code);
    unique case (code)
      `PMC_FRQ_8M: decodeFreq = `PMC_FRQ_8M;
      `PMC_FRQ_12M: decodeFreq = `PMC_FRQ_12M;
      default: decodeFreq = `PMC_FRQ_4M;
    endcase
  endfunction : decodeFreq

  // Clock mode is low power when not fast or slow
  function automatic logic isLowPower(input pmc_mode_t m);
    isLowPower = (m != PMC_FAST) && (m != PMC_SLOW);
  endfunction : isLowPower

  logic rstSync1_reg;
  logic rstN;
  logic fastOscEn_reg;
  logic [1:0] freqSel_reg;
  logic fastStable_reg;
  logic [15:0] settleCnt_reg;
  logic [2:0] sysSel_reg;
  logic fastKeep_reg;
  logic slowKeep_reg;
  logic [PORT_W-1:0] wakeEn_reg;
  logic [2:0] curSel_reg;
  logic switchBusy_reg;
  logic [31:0] switchCnt_reg;
  logic [31:0] switchLoad;
  pmc_mode_t mode_reg;
  logic [IRQ_W-1:0] irqBlock_reg;
  logic [PORT_W-1:0] portMeta_reg;
  logic [PORT_W-1:0] portSync_reg;
  logic [PORT_W-1:0] portPrev_reg;
  logic portWake;
  logic irqWake;
  logic haltTake;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [`PMC_ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic wLane0_reg;
  logic wrFire;
  logic [31:0] rdValue;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_reg <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN <= rstSync1_reg;
    end
  end

  // Write address and data channels, either order
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wLane0_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end else if (wrFire) begin
        awHeld_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wLane0_reg <= wstrb[0];
      end else if (wrFire) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  assign wrFire = awHeld_reg && wHeld_reg && !bvalid;

  // Channel readies and write response
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `PMC_RESP_OKAY;
    end else begin
      awready <= !awHeld_reg && !(awvalid && awready) && !bvalid;
      wready <= !wHeld_reg && !(wvalid && wready) && !bvalid;
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp <= (awAddr_reg == `PMC_OFS_FOSC || awAddr_reg == `PMC_OFS_SCC ||
                  awAddr_reg == `PMC_OFS_WAKE || awAddr_reg == `PMC_OFS_STAT) ?
                 `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Register read mux
  always_comb begin
    rdValue = 32'h0000_0000;
    unique case (araddr)
      `PMC_OFS_FOSC: begin
        rdValue[`PMC_FOSC_EN_BIT] = fastOscEn_reg;
        rdValue[`PMC_FOSC_STB_BIT] = fastStable_reg;
        rdValue[`PMC_FOSC_FRQ_LO +: 2] = freqSel_reg; // bits 7:4 stay zero
      end
      `PMC_OFS_SCC: begin
        rdValue[`PMC_SCC_SKEEP_BIT] = slowKeep_reg;
        rdValue[`PMC_SCC_FKEEP_BIT] = fastKeep_reg;
        rdValue[`PMC_SCC_SEL_LO +: 3] = sysSel_reg;
      end
      `PMC_OFS_WAKE: rdValue[PORT_W-1:0] = wakeEn_reg;
      `PMC_OFS_STAT: begin
        rdValue[0] = powerdownFlag;
        rdValue[1] = wdtTimeoutFlag;
        rdValue[13:8] = mode_reg;
        rdValue[18:16] = curSel_reg;
        rdValue[19] = switchBusy_reg;
        rdValue[21:20] = clkCtl.fastFreq;
      end
      default: rdValue = 32'h0000_0000;
    endcase
  end

  // Read channel
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PMC_RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rdValue;
        rresp <= (araddr == `PMC_OFS_FOSC || araddr == `PMC_OFS_SCC ||
                  araddr == `PMC_OFS_WAKE || araddr == `PMC_OFS_STAT) ?
                 `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Software-written control fields
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      fastOscEn_reg <= `PMC_FOSC_EN_RST;
      freqSel_reg <= `PMC_FOSC_FRQ_RST;
      sysSel_reg <= `PMC_SCC_SEL_RST;
      fastKeep_reg <= 1'b0;
      slowKeep_reg <= 1'b0;
      wakeEn_reg <= '0;
    end else if (wrFire && wLane0_reg) begin
      unique case (awAddr_reg)
        `PMC_OFS_FOSC: begin
          fastOscEn_reg <= wData_reg[`PMC_FOSC_EN_BIT];
          freqSel_reg <= wData_reg[`PMC_FOSC_FRQ_LO +: 2];
        end
        `PMC_OFS_SCC: begin
          sysSel_reg <= wData_reg[`PMC_SCC_SEL_LO +: 3];
          fastKeep_reg <= wData_reg[`PMC_SCC_FKEEP_BIT];
          slowKeep_reg <= wData_reg[`PMC_SCC_SKEEP_BIT];
        end
        `PMC_OFS_WAKE: wakeEn_reg <= wData_reg[PORT_W-1:0];
        default: ;
      endcase
    end
  end

  // Fast oscillator settle tracking and stable flag
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      settleCnt_reg <= '0;
      fastStable_reg <= 1'b0;
    end else if (!clkCtl.fastOscOn || (wrFire && wLane0_reg && awAddr_reg == `PMC_OFS_FOSC &&
             (wData_reg[`PMC_FOSC_FRQ_LO +: 2] != freqSel_reg ||
              (wData_reg[`PMC_FOSC_EN_BIT] && !fastOscEn_reg)))) begin
      settleCnt_reg <= '0; // restart on enable or new frequency
      fastStable_reg <= 1'b0;
    end else if (settleCnt_reg < 16'(SETTLE_CYC)) begin
      settleCnt_reg <= settleCnt_reg + 16'h0001;
    end else begin
      fastStable_reg <= fastOscReady;
    end
  end

  // Cycles for the switch: four current system clock periods
  assign switchLoad = (curSel_reg == `PMC_SEL_SUB) ?
                      32'(`PMC_SWITCH_PERIODS * SUB_PERIOD_CYC) :
                      32'((`PMC_SWITCH_PERIODS * FAST_PERIOD_CYC) << curSel_reg);

  // System clock source switching
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      curSel_reg <= `PMC_SCC_SEL_RST;
      switchBusy_reg <= 1'b0;
      switchCnt_reg <= '0;
    end else if (switchBusy_reg) begin
      if (switchCnt_reg <= 32'h0000_0001) begin
        switchBusy_reg <= 1'b0;
        curSel_reg <= sysSel_reg;
      end else begin
        switchCnt_reg <= switchCnt_reg - 32'h0000_0001;
      end
    end else if (!isLowPower(mode_reg) && sysSel_reg != curSel_reg) begin
      if (sysSel_reg == `PMC_SEL_SUB && slowOscStable) begin
        switchBusy_reg <= 1'b1;
        switchCnt_reg <= switchLoad;
      end else if (sysSel_reg != `PMC_SEL_SUB && fastStable_reg) begin
        switchBusy_reg <= 1'b1;
        switchCnt_reg <= switchLoad;
      end
    end
  end

  // Port A edge detection on the free-running clock
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      portMeta_reg <= '1;
      portSync_reg <= '1;
      portPrev_reg <= '1;
    end else begin
      portMeta_reg <= portAIn;
      portSync_reg <= portMeta_reg;
      portPrev_reg <= portSync_reg;
    end
  end

  assign portWake = |(wakeEn_reg & portPrev_reg & ~portSync_reg);
  assign irqWake = |(irqReq & ~irqBlock_reg);
  assign haltTake = haltReq && !isLowPower(mode_reg) && !switchBusy_reg;

  // Operating mode state machine and core events
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mode_reg <= PMC_FAST;
      irqBlock_reg <= '0;
      evt <= '0;
    end else begin
      evt <= '0;
      unique case (mode_reg)
        PMC_FAST, PMC_SLOW: begin
          mode_reg <= (curSel_reg == `PMC_SEL_SUB) ? PMC_SLOW : PMC_FAST;
          if (haltTake) begin
            irqBlock_reg <= irqReq;
            evt.wdtClear <= 1'b1;
            unique case ({fastKeep_reg, slowKeep_reg})
              2'b00: mode_reg <= PMC_SLEEP;
              2'b01: mode_reg <= PMC_IDLE_SUB;
              2'b11: mode_reg <= PMC_IDLE_BOTH;
              2'b10: mode_reg <= PMC_IDLE_FAST;
            endcase
          end
        end
        PMC_SLEEP, PMC_IDLE_SUB, PMC_IDLE_BOTH, PMC_IDLE_FAST: begin
          if (wdtOverflow || portWake || irqWake) begin
            mode_reg <= (curSel_reg == `PMC_SEL_SUB) ? PMC_SLOW : PMC_FAST;
            irqBlock_reg <= '0;
            if (wdtOverflow) begin
              evt.pcSpReset <= 1'b1;
            end else if (!portWake && |(irqReq & ~irqBlock_reg & irqEnable) && !stackFull) begin
              evt.irqService <= 1'b1;
            end else begin
              evt.resumeNext <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Status flags; set wins over clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      powerdownFlag <= 1'b0;
      wdtTimeoutFlag <= 1'b0;
    end else begin
      if (haltTake) begin
        powerdownFlag <= 1'b1;
      end else if (clrWdtReq) begin
        powerdownFlag <= 1'b0;
      end
      if (wdtOverflow) begin
        wdtTimeoutFlag <= 1'b1;
      end else if (haltTake) begin
        wdtTimeoutFlag <= 1'b0;
      end
    end
  end

  // Clock gating and oscillator power per mode
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      clkCtl <= '0;
      clkCtl.fastFreq <= `PMC_FRQ_4M; // Reset code decodes to 4 MHz
    end else begin
      clkCtl.sysClkSel <= curSel_reg;
      if (fastStable_reg) begin
        clkCtl.fastFreq <= decodeFreq(freqSel_reg);
      end
      clkCtl.holdState <= isLowPower(mode_reg);
      unique case (mode_reg)
        PMC_FAST, PMC_SLOW: begin
          clkCtl.cpuRun <= 1'b1;
          clkCtl.sysClkOn <= 1'b1;
          clkCtl.fastOscOn <= fastOscEn_reg || curSel_reg != `PMC_SEL_SUB;
          clkCtl.fastClkOn <= fastOscEn_reg || curSel_reg != `PMC_SEL_SUB;
          clkCtl.subClkOn <= 1'b1;
        end
        PMC_SLEEP: begin
          clkCtl.cpuRun <= 1'b0;
          clkCtl.sysClkOn <= 1'b0;
          clkCtl.fastOscOn <= 1'b0;
          clkCtl.fastClkOn <= 1'b0;
          clkCtl.subClkOn <= 1'b0;
        end
        PMC_IDLE_SUB: begin
          clkCtl.cpuRun <= 1'b0;
          clkCtl.sysClkOn <= curSel_reg == `PMC_SEL_SUB;
          clkCtl.fastOscOn <= 1'b0;
          clkCtl.fastClkOn <= 1'b0;
          clkCtl.subClkOn <= 1'b1;
        end
        PMC_IDLE_BOTH: begin
          clkCtl.cpuRun <= 1'b0;
          clkCtl.sysClkOn <= 1'b1;
          clkCtl.fastOscOn <= 1'b1;
          clkCtl.fastClkOn <= 1'b1;
          clkCtl.subClkOn <= 1'b1;
        end
        PMC_IDLE_FAST: begin
          clkCtl.cpuRun <= 1'b0;
          clkCtl.sysClkOn <= curSel_reg != `PMC_SEL_SUB;
          clkCtl.fastOscOn <= 1'b1;
          clkCtl.fastClkOn <= 1'b1;
          clkCtl.subClkOn <= 1'b0;
        end
      endcase
    end
  end
endmodule : pmc_power_ctrl
`default_nettype wire

//--- test/pmc_core_model.sv
// Core and oscillator model facing the controller
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model import pmc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic slowOn,
  input wire pmc_clk_t clkCtl,
  input wire pmc_evt_t evt,
  output logic fastOscReady,
  output logic slowOscStable,
  output logic [3:0] seen
);
  // Fast oscillator answers only while powered; slow one follows slowOn
  assign fastOscReady = clkCtl.fastOscOn;
  assign slowOscStable = slowOn;
  // Sticky record of core events since the last halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen <= 4'h0;
    end else if (clr) begin
      seen <= 4'h0;
    end else begin
      seen <= seen | evt;
    end
  end
endmodule : pmc_core_model
`default_nettype wire

//--- test/pmc_power_ctrl_checker.sv
// Port assertions for the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl_checker import pmc_pkg::*; #(
  parameter int IRQ_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic haltReq,
  input wire logic clrWdtReq,
  input wire logic wdtOverflow,
  input wire logic [IRQ_W-1:0] irqReq,
  input wire logic [IRQ_W-1:0] irqEnable,
  input wire logic stackFull,
  input wire pmc_clk_t clkCtl,
  input wire pmc_evt_t evt,
  input wire logic powerdownFlag,
  input wire logic wdtTimeoutFlag
);
  logic irqLive_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Serviceable interrupt seen last edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqLive_reg <= 1'h0;
    end else begin
      irqLive_reg <= (|(irqReq & irqEnable)) && !stackFull;
    end
  end
  a_halt_sets_flags: assert property (evt.wdtClear |-> ##[0:1]
    (powerdownFlag && !wdtTimeoutFlag)) else $error("halt entry flags wrong");
  a_clear_needs_halt: assert property (
    evt.wdtClear |-> $past(haltReq) || $past(haltReq, 2)) else $error("stray wdt clear");
  a_pdf_rise_cause: assert property (
    $rose(powerdownFlag) |-> $past(haltReq) || $past(haltReq, 2)) else $error("pdf set alone");
  a_pdf_clear: assert property (
    clrWdtReq && !haltReq && !$past(haltReq) |=> !powerdownFlag) else $error("pdf kept");
  a_to_rise_cause: assert property ($rose(wdtTimeoutFlag) |->
    $past(wdtOverflow) || $past(wdtOverflow, 2)) else $error("timeout flag set alone");
  a_wdt_wake_flag: assert property (
    evt.pcSpReset |-> ##[0:1] wdtTimeoutFlag) else $error("wdt wake without flag");
  a_freq_legal: assert property (clkCtl.fastFreq != 2'h3) else $error("bad freq");
  a_sleep_no_sys: assert property (
    !clkCtl.fastClkOn && !clkCtl.subClkOn |-> !clkCtl.sysClkOn) else $error("sysclk on");
  a_halt_stops_cpu: assert property (
    evt.wdtClear |-> ##[0:2] !clkCtl.cpuRun) else $error("cpu still runs");
  a_resume_no_svc: assert property (
    evt.resumeNext |-> !evt.irqService) else $error("resume with service");
  a_svc_cause: assert property (evt.irqService |-> irqLive_reg ||
    $past(irqLive_reg) || $past(irqLive_reg, 2)) else $error("service without cause");
  c_halt: cover property (evt.wdtClear);
  c_wdt_wake: cover property (evt.pcSpReset);
  c_resume: cover property (evt.resumeNext);
  c_service: cover property (evt.irqService);
endmodule : pmc_power_ctrl_checker
bind pmc_power_ctrl pmc_power_ctrl_checker #(.IRQ_W(IRQ_W)) chk_u (.*);
`default_nettype wire

//--- test/pmc_tb.sv
// Self-checking bench for the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defines.svh"
module tb import pmc_pkg::*;;
  localparam int SUBC = 8;
  logic clk = 1'h0, nrst = 1'h0, slowOn = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic haltReq = 1'h0, clrWdtReq = 1'h0, wdtOverflow = 1'h0, stackFull = 1'h0;
  logic [7:0] irqReq = 8'h0, irqEnable = 8'h0, portAIn = 8'hFF;
  logic awready, wready, bvalid, arready, rvalid, fastOscReady, slowOscStable;
  logic powerdownFlag, wdtTimeoutFlag;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rv;
  logic [3:0] seen;
  pmc_clk_t clkCtl;
  pmc_evt_t evt;
  int errorCnt = 0, testsRun = 0, cyc = 0, t0, c, old = 0;
  logic [3:0] lane = 4'hF;
  pmc_mode_t modeT [4] = '{PMC_SLEEP, PMC_IDLE_SUB, PMC_IDLE_BOTH, PMC_IDLE_FAST};
  logic [7:0] sccT [4] = '{8'hC0, 8'hC1, 8'hC3, 8'hC2};
  logic [2:0] clkT [4] = '{3'h0, 3'h1, 3'h3, 3'h2};
  logic [3:0] evT [4] = '{4'hC, 4'hA, 4'h9, 4'hA};
  pmc_power_ctrl #(.SUB_PERIOD_CYC(SUBC)) dut_u (.*);
  pmc_core_model core_u (.clk(clk), .nrst(nrst), .clr(haltReq), .slowOn(slowOn),
    .clkCtl(clkCtl), .evt(evt), .fastOscReady(fastOscReady),
    .slowOscStable(slowOscStable), .seen(seen));
  // Clock and cycle count
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic reportAndStop();
    $display("Checks %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : reportAndStop
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic tmo();
    check("wait", 32'h1, 32'h0);
    reportAndStop();
  endtask : tmo
  // Register bus write, both channels offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= lane;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (++n > 400) tmo();
    end while (!bvalid);
    bready <= 1'h0;
    r = bresp;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (++n > 400) tmo();
    end while (!rvalid);
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] m,
    input logic [31:0] e);
    rd(a, rv, rsp);
    check(nm, e, rv & m);
  endtask : rdc
  // Poll a register until the masked value matches
  task automatic wst(input string nm, input logic [3:0] a, input logic [31:0] m,
    input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(a, rv, rsp);
      if (++n > 3000) tmo();
    end while ((rv & m) !== e);
    check(nm, e, rv & m);
  endtask : wst
  task automatic hlt();
    @(posedge clk);
    haltReq <= 1'h1;
    @(posedge clk);
    haltReq <= 1'h0;
  endtask : hlt
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    rdc("fosc_rst", `PMC_OFS_FOSC, 32'hFD, 32'h1);
    rdc("scc_rst", `PMC_OFS_SCC, 32'hFF, 32'h0);
    rdc("wake_rst", `PMC_OFS_WAKE, 32'hFF, 32'h0);
    // Write with the low byte lane off is accepted but changes nothing
    lane = 4'hE;
    wr(`PMC_OFS_WAKE, 32'hFF, rsp);
    lane = 4'hF;
    check("lane_off", `PMC_RESP_OKAY, rsp);
    rdc("lane_keep", `PMC_OFS_WAKE, 32'hFF, 32'h0);
    rdc("stat_rst", `PMC_OFS_STAT, 32'h3F03, 32'h100);
    rd(4'h6, rv, rsp);
    check("unmap_rd", `PMC_RESP_SLVERR, rsp);
    wr(4'h6, 32'hFF, rsp);
    check("unmap_wr", `PMC_RESP_SLVERR, rsp);
    wst("fosc_stable", `PMC_OFS_FOSC, 32'h2, 32'h2);
    // Every frequency code, ending on the reset code 0
    for (int j = 0; j < 4; j++) begin
      c = (j + 1) % 4;
      wr(`PMC_OFS_FOSC, 32'hF1 | (c << 2), rsp);
      rdc("fosc_clr", `PMC_OFS_FOSC, 32'hFF, 32'h1 | (c << 2));
      rdc("freq_hold", `PMC_OFS_STAT, 32'h300000, old << 20);
      old = (c == 3) ? 0 : c;
      wst("freq_new", `PMC_OFS_STAT, 32'h300000, old << 20);
      check("freq_out", old, clkCtl.fastFreq);
    end
    // Slow switch held back while the slow oscillator is unstable
    slowOn <= 1'h0;
    wr(`PMC_OFS_SCC, 32'hE0, rsp);
    repeat (200) @(posedge clk);
    rdc("slow_wait", `PMC_OFS_STAT, 32'h3F00, 32'h100);
    slowOn <= 1'h1;
    for (int k = 0; k < 7; k++) begin
      wr(`PMC_OFS_SCC, 32'hE0, rsp);
      wst("to_slow", `PMC_OFS_STAT, 32'h73F00, 32'h70200);
      t0 = cyc;
      wr(`PMC_OFS_SCC, k << 5, rsp);
      wst("to_fast", `PMC_OFS_STAT, 32'h73F00, (k << 16) | 32'h100);
      check("sw_time", 1, cyc - t0 >= 4 * SUBC && cyc - t0 <= 6 * SUBC + 39);
      check("sel_out", k, clkCtl.sysClkSel);
    end
    // Each low power mode with a wake source: watchdog, port A, interrupt, interrupt with stack full
    wr(`PMC_OFS_WAKE, 32'h1, rsp);
    for (int i = 0; i < 4; i++) begin
      wr(`PMC_OFS_SCC, sccT[i], rsp);
      if (i == 3) begin
        irqEnable <= 8'h3;
        irqReq <= 8'h1;
        stackFull <= 1'h1;
      end
      hlt();
      wst("lp_mode", `PMC_OFS_STAT, 32'h3F03, {modeT[i], 8'h1});
      check("lp_clk", clkT[i], {clkCtl.cpuRun, clkCtl.fastClkOn, clkCtl.subClkOn});
      check("lp_hold", {1'b1, i >= 2}, {clkCtl.holdState, clkCtl.sysClkOn});
      rdc("lp_keep", `PMC_OFS_SCC, 32'hFF, sccT[i]);
      check("wdt_clr", 1, seen[3]);
      if (i == 1) portAIn <= 8'hFD;
      repeat (20) @(posedge clk);
      rdc("no_wake", `PMC_OFS_STAT, 32'h3F00, {modeT[i], 8'h0});
      case (i)
        0: wdtOverflow <= 1'h1;
        1: portAIn <= 8'hFC;
        2: begin
          irqEnable <= 8'h1;
          irqReq <= 8'h1;
        end
        default: irqReq <= 8'h3;
      endcase
      @(posedge clk);
      wdtOverflow <= 1'h0;
      wst("wake_mode", `PMC_OFS_STAT, 32'h3F00, 32'h100);
      rdc("wake_flags", `PMC_OFS_STAT, 32'h3, (i == 0) ? 32'h3 : 32'h1);
      check("run_hold", 2'b10, {clkCtl.cpuRun, clkCtl.holdState});
      check("wake_evt", evT[i], seen);
      portAIn <= 8'hFF;
      irqReq <= 8'h0;
      irqEnable <= 8'h0;
      stackFull <= 1'h0;
    end
    clrWdtReq <= 1'h1;
    @(posedge clk);
    clrWdtReq <= 1'h0;
    rdc("pdf_clr", `PMC_OFS_STAT, 32'h1, 32'h0);
    reportAndStop();
  end
endmodule : tb
`default_nettype wire
